// file: rtl/pcfr_regs.sv
// Purpose: Control-frame configuration and paged diagnostic registers
// Assumes: Management access decoded elsewhere into read/write strobes
// Notes:   Reads are answered one cycle after the read strobe
`timescale 1ns/1ps
`include "pcfr_params.svh"

// Functional notes
// - Error flag sets on faulty control frame, cleared by register read.
// - Success flag sets on good control frame, cleared by register read.
// - Bits 13 to 9 ignore writes and read zero.
// - Select bit picks one of two fixed destination addresses.
// - Also accept selected address with multicast bit set.
// - Interrupt field: 00 off, low bit success, high bit error.
// - When enabled, frame interrupt replaces receive-half-full source.
// - Broadcast PHY address accepted unless disable bit set.
// - Buffer size sets transmit delay; zero truncates after address.
// - Frame write enable resets from strap; allows in-frame writes.
// - Page 1 registers visible only when page select is 001.
// - Page 2 registers visible only when page select is 010.
// - Time bit selects about 1 us or 250 us loss detection.
// - Cable length read-only, resets all ones, upper byte zero.
module pcfr_regs
    import pcfr_pkg::*;
#(
    parameter logic [47:0] DEST_ADDR_A = 48'h0a_00_00_00_00_01, // Arbitrary
    parameter logic [47:0] DEST_ADDR_B = 48'h0a_00_00_00_00_00, // Arbitrary
    parameter int          SLOW_CYC    = `PCFR_SLOW_LOSS_CYC
) (
    input  wire logic        clk_sys_in,        // System clock
    input  wire logic        rst_in,            // Async reset, active high
    input  wire logic        strap_frame_en_in, // Strap for write enable
    input  wire logic [2:0]  page_select_in,    // Page select bits 2:0
    input  wire logic [4:0]  reg_addr_in,       // Register address
    input  wire logic        reg_wr_in,         // Write strobe
    input  wire logic        reg_rd_in,         // Read strobe
    input  wire logic [15:0] reg_wdata_in,      // Write data
    input  wire logic        frame_done_in,     // Control frame ended
    input  wire logic        frame_fault_in,    // Ended frame was faulty
    input  wire logic [47:0] frame_da_in,       // Received destination addr
    input  wire logic [4:0]  frame_phy_addr_in, // Frame PHY address field
    input  wire logic [4:0]  own_phy_addr_in,   // Device PHY address
    input  wire logic        link_100_in,       // Link up at 100 Mb
    input  wire logic [7:0]  length_meters_in,  // Length from DSP
    input  wire logic        length_valid_in,   // Length estimate valid
    input  wire logic        sig_detect_in,     // Raw signal detect (pin)
    output logic [15:0]      reg_rdata_out,     // Read data
    output logic             reg_hit_out,       // Read address decoded
    output logic             frame_accept_out,  // Frame addressed to us
    output logic             frame_write_en_out,// In-frame writes allowed
    output logic [3:0]       detect_buffer_size_out, // Transmit delay depth
    output logic             truncate_frame_out,// Truncate after address
    output logic             frame_irq_out,     // Frame interrupt event
    output logic             irq_source_sel_out,// Frame replaces RECEIVE_HALF_FULL_IRQ irq
    output logic             link_ok_out        // Filtered signal good
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic        err_reg, err_next;
    logic        ok_reg, ok_next;
    logic        da_sel_reg, da_sel_next;
    logic [1:0]  irq_sel_reg, irq_sel_next;
    logic        bc_dis_reg, bc_dis_next;
    logic [3:0]  buf_reg, buf_next;
    logic        en_reg, en_next;
    logic        strap_done_reg, strap_done_next;
    logic [15:0] sd_reg, sd_next;
    logic [7:0]  len_reg, len_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        hit_reg, hit_next;
    logic        accept_reg, accept_next;
    logic        irq_reg, irq_next;
    logic        trunc_reg, trunc_next;
    logic        isel_reg, isel_next;
    logic        sd_s1_reg, sd_s2_reg;
    logic        filt_ok;

    // Address decode with page gating
    logic sel_cf, sel_sd, sel_len;
    logic [47:0] da_sel_addr;
    logic        da_match, phy_match, good_evt, bad_evt;

    always_comb begin
        sel_cf  = (reg_addr_in == `PCFR_ADDR_CF_CONFIG) &&
                  (page_select_in == 3'h0);
        sel_sd  = (reg_addr_in == `PCFR_ADDR_SD_CONFIG) &&
                  (page_select_in == `PCFR_PAGE_TEST);
        sel_len = (reg_addr_in == `PCFR_ADDR_LENGTH_METERS) &&
                  (page_select_in == `PCFR_PAGE_DIAG);
        da_sel_addr = da_sel_reg ? DEST_ADDR_B : DEST_ADDR_A;
        da_match = (frame_da_in == da_sel_addr) ||
                   (frame_da_in == (da_sel_addr | `PCFR_DA_MCAST_BIT));
        phy_match = (frame_phy_addr_in == own_phy_addr_in) ||
                    (!bc_dis_reg &&
                     frame_phy_addr_in == `PCFR_BCAST_PHY_ADDR);
        // Only frames addressed to us count as control-frame events
        good_evt = frame_done_in && da_match && phy_match && !frame_fault_in;
        bad_evt  = frame_done_in && da_match && phy_match && frame_fault_in;
    end

    // Next values of the register bank
    always_comb begin
        err_next        = err_reg;
        ok_next         = ok_reg;
        da_sel_next     = da_sel_reg;
        irq_sel_next    = irq_sel_reg;
        bc_dis_next     = bc_dis_reg;
        buf_next        = buf_reg;
        en_next         = en_reg;
        strap_done_next = 1'b1;
        sd_next         = sd_reg;
        len_next        = length_valid_in ? length_meters_in
                                          : `PCFR_CABLE_RESET;
        rdata_next      = 16'h0000;
        hit_next        = reg_rd_in && (sel_cf || sel_sd || sel_len);
        // Strap captured once after reset release
        if (!strap_done_reg) begin
            en_next = strap_frame_en_in;
        end
        // Read returns flags then clears them both
        if (reg_rd_in && sel_cf) begin
            rdata_next = {err_reg, ok_reg, 5'h00, da_sel_reg, irq_sel_reg,
                          bc_dis_reg, buf_reg, en_reg};
            err_next = 1'b0;
            ok_next  = 1'b0;
        end else if (reg_rd_in && sel_sd) begin
            rdata_next = sd_reg;
        end else if (reg_rd_in && sel_len) begin
            rdata_next = {8'h00, len_reg};
        end
        // Events win over the read clear
        if (bad_evt) begin
            err_next = 1'b1;
        end
        if (good_evt) begin
            ok_next = 1'b1;
        end
        // Writes; reserved and status bits are ignored
        if (reg_wr_in && sel_cf) begin
            da_sel_next  = reg_wdata_in[`PCFR_BIT_DA_SEL];
            irq_sel_next = reg_wdata_in[`PCFR_IRQ_HI:`PCFR_IRQ_LO];
            bc_dis_next  = reg_wdata_in[`PCFR_BIT_BC_DIS];
            buf_next     = reg_wdata_in[`PCFR_BUF_HI:`PCFR_BUF_LO];
            en_next      = reg_wdata_in[`PCFR_BIT_EN];
        end
        if (reg_wr_in && sel_sd) begin
            sd_next = (reg_wdata_in & 16'hf7ff) | `PCFR_SD_FIXED_ONE;
        end
        // Derived outputs are registered so they leave straight from flops
        trunc_next = (buf_next == 4'h0);
        isel_next  = |irq_sel_next;
    end

    // Frame and interrupt outputs
    always_comb begin
        accept_next = frame_done_in && da_match && phy_match;
        irq_next    = (good_evt && irq_sel_reg[0]) ||
                      (bad_evt && irq_sel_reg[1]);
    end

    // Register bank flops
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            err_reg        <= 1'b0;
            ok_reg         <= 1'b0;
            da_sel_reg     <= 1'b0;
            irq_sel_reg    <= 2'h0;
            bc_dis_reg     <= 1'b0;
            buf_reg        <= 4'h0;
            en_reg         <= 1'b0;
            strap_done_reg <= 1'b0;
            sd_reg         <= `PCFR_SD_FIXED_ONE;
            len_reg        <= `PCFR_CABLE_RESET;
            rdata_reg      <= 16'h0000;
            hit_reg        <= 1'b0;
            accept_reg     <= 1'b0;
            irq_reg        <= 1'b0;
            trunc_reg      <= 1'b0;
            isel_reg       <= 1'b0;
        end else begin
            err_reg        <= err_next;
            ok_reg         <= ok_next;
            da_sel_reg     <= da_sel_next;
            irq_sel_reg    <= irq_sel_next;
            bc_dis_reg     <= bc_dis_next;
            buf_reg        <= buf_next;
            en_reg         <= en_next;
            strap_done_reg <= strap_done_next;
            sd_reg         <= sd_next;
            len_reg        <= len_next;
            rdata_reg      <= rdata_next;
            hit_reg        <= hit_next;
            accept_reg     <= accept_next;
            irq_reg        <= irq_next;
            trunc_reg      <= trunc_next;
            isel_reg       <= isel_next;
        end
    end

    // Signal detect synchroniser
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sd_s1_reg <= 1'b0;
            sd_s2_reg <= 1'b0;
        end else begin
            sd_s1_reg <= sig_detect_in;
            sd_s2_reg <= sd_s1_reg;
        end
    end

    // Loss-of-signal filter
    pcfr_loss_filter #(
        .SLOW_CYC (SLOW_CYC),
        .FAST_CYC (`PCFR_FAST_LOSS_CYC)
    ) u_loss (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .sig_in     (sd_s2_reg),
        .fast_in    (sd_reg[`PCFR_BIT_FAST_LOSS_SELECT]),
        .sig_ok_out (filt_ok)
    );

    // Outputs straight from flops
    assign reg_rdata_out          = rdata_reg;
    assign reg_hit_out            = hit_reg;
    assign frame_accept_out       = accept_reg;
    assign frame_write_en_out     = en_reg;
    assign detect_buffer_size_out = buf_reg;
    assign truncate_frame_out     = trunc_reg;
    assign frame_irq_out          = irq_reg;
    assign irq_source_sel_out     = isel_reg;
    assign link_ok_out            = filt_ok;

endmodule

// file: pkg/pcfr_params.svh
// Purpose: Constants for the control-frame and diagnostic register bank
// Assumes: Included by the design modules
// Notes:   Addresses are the 5-bit management register addresses
`ifndef PCFR_PARAMS_SVH
`define PCFR_PARAMS_SVH

// ****************************************************************
// Register addresses and pages
// ****************************************************************
`define PCFR_ADDR_LENGTH_METERS   5'h14
`define PCFR_ADDR_SD_CONFIG   5'h1e
`define PCFR_ADDR_CF_CONFIG   5'h1f
`define PCFR_PAGE_TEST        3'h1
`define PCFR_PAGE_DIAG        3'h2

// ****************************************************************
// Field positions of the control-frame configuration register, plus the fast-loss select bit of the detect config register
// ****************************************************************
`define PCFR_BIT_ERR          15
`define PCFR_BIT_OK           14
`define PCFR_BIT_DA_SEL       8
`define PCFR_IRQ_HI           7
`define PCFR_IRQ_LO           6
`define PCFR_BIT_BC_DIS       5
`define PCFR_BUF_HI           4
`define PCFR_BUF_LO           1
`define PCFR_BIT_EN           0
`define PCFR_BIT_FAST_LOSS_SELECT      8

// ****************************************************************
// Reset values and matching constants
// ****************************************************************
`define PCFR_SD_FIXED_ONE     16'h8000
`define PCFR_CABLE_RESET      8'hff
`define PCFR_BCAST_PHY_ADDR   5'h1f
`define PCFR_DA_MCAST_BIT     48'h0100_0000_0000

// ****************************************************************
// Signal-loss detection times (ns) and cycle counts at 250 MHz
// ****************************************************************
`define PCFR_CLK_PERIOD_NS    4
`define PCFR_FAST_LOSS_NS     1000
`define PCFR_SLOW_LOSS_NS     250000
`define PCFR_FAST_LOSS_CYC    (`PCFR_FAST_LOSS_NS / `PCFR_CLK_PERIOD_NS)
`define PCFR_SLOW_LOSS_CYC    (`PCFR_SLOW_LOSS_NS / `PCFR_CLK_PERIOD_NS)

`endif

// file: pkg/pcfr_pkg.sv
// Purpose: Types for the control-frame and diagnostic register bank
// Assumes: Nothing
// Notes:   Constants live in pcfr_params.svh
package pcfr_pkg;

    // Loss filter states
    typedef enum logic [1:0] {
        PCFR_SIG_UP,
        PCFR_SIG_TIMING,
        PCFR_SIG_LOST
    } pcfr_sig_state_t;

endpackage

// file: rtl/pcfr_loss_filter.sv
// Purpose: Filters loss of signal detect before reporting link loss
// Assumes: sig_in already synchronised to clk_sys_in
// Notes:   Loss is reported once signal stays low for the selected time
`timescale 1ns/1ps
`include "pcfr_params.svh"

module pcfr_loss_filter
    import pcfr_pkg::*;
#(
    parameter int SLOW_CYC = `PCFR_SLOW_LOSS_CYC,
    parameter int FAST_CYC = `PCFR_FAST_LOSS_CYC
) (
    input  wire logic clk_sys_in,     // System clock
    input  wire logic rst_in,         // Async reset, active high
    input  wire logic sig_in,         // Synchronised signal detect
    input  wire logic fast_in,        // Fast loss selected
    output logic      sig_ok_out      // Filtered signal good
);

    pcfr_sig_state_t state_reg;
    pcfr_sig_state_t state_next;
    logic [31:0]     cnt_reg;
    logic [31:0]     cnt_next;
    logic            ok_reg;
    logic            ok_next;
    logic [31:0]     limit;

    // Next state of the loss filter
    always_comb begin
        limit      = fast_in ? FAST_CYC[31:0] : SLOW_CYC[31:0];
        state_next = state_reg;
        cnt_next   = cnt_reg;
        ok_next    = ok_reg;
        case (state_reg)
            PCFR_SIG_UP: begin
                ok_next  = 1'b1;
                cnt_next = 32'h0000_0001;
                if (!sig_in) begin
                    state_next = PCFR_SIG_TIMING;
                end
            end
            PCFR_SIG_TIMING: begin
                if (sig_in) begin
                    state_next = PCFR_SIG_UP;
                end else if (cnt_reg >= limit) begin
                    state_next = PCFR_SIG_LOST;
                    ok_next    = 1'b0;
                end else begin
                    cnt_next = cnt_reg + 32'h0000_0001;
                end
            end
            PCFR_SIG_LOST: begin
                ok_next = 1'b0;
                if (sig_in) begin
                    state_next = PCFR_SIG_UP;
                    ok_next    = 1'b1;
                end
            end
            default: begin
                state_next = PCFR_SIG_LOST;
                ok_next    = 1'b0;
            end
        endcase
    end

    // Filter registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= PCFR_SIG_LOST;
            cnt_reg   <= 32'h0000_0000;
            ok_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            ok_reg    <= ok_next;
        end
    end

    assign sig_ok_out = ok_reg;

endmodule

// file: tb/pcfr_regs_assertions.sv
// Purpose: Port-level checks on the control-frame register bank
// Assumes: Reads answer exactly one cycle after the read strobe
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module pcfr_regs_assertions #(
    parameter int SLOW_CYC = 62500
) (
    input wire logic        clk_sys_in,         // Clock
    input wire logic        rst_in,             // Reset
    input wire logic [2:0]  page_select_in,     // Page
    input wire logic [4:0]  reg_addr_in,        // Address
    input wire logic        reg_wr_in,          // Write strobe
    input wire logic        reg_rd_in,          // Read strobe
    input wire logic        frame_done_in,      // Frame ended
    input wire logic [15:0] reg_rdata_out,      // Read data
    input wire logic        reg_hit_out,        // Read hit
    input wire logic        frame_accept_out,   // Frame accepted
    input wire logic        frame_write_en_out, // Write enable
    input wire logic [3:0]  detect_buffer_size_out, // Buffer size
    input wire logic        truncate_frame_out, // Truncate
    input wire logic        frame_irq_out,      // Frame irq
    input wire logic        irq_source_sel_out  // Irq source
);
    // ************************************************************
    // Register and frame checks
    // ************************************************************
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_hit; reg_hit_out |-> $past(reg_rd_in); endproperty
    a_hit: assert property (p_hit) else $error("hit without read");
    property p_rsvd;
        $past(reg_rd_in) && $past(reg_addr_in) == 5'h1f
        && $past(page_select_in) == 3'h0
        |-> reg_hit_out && reg_rdata_out[13:9] == 5'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits");
    property p_sd;
        $past(reg_rd_in) && $past(reg_addr_in) == 5'h1e
        && $past(page_select_in) == 3'h1
        |-> reg_rdata_out[15] && !reg_rdata_out[11];
    endproperty
    a_sd: assert property (p_sd) else $error("detect config fixed bits");
    property p_len;
        $past(reg_rd_in) && $past(reg_addr_in) == 5'h14
        && $past(page_select_in) == 3'h2
        |-> reg_hit_out && reg_rdata_out[15:8] == 8'h0;
    endproperty
    a_len: assert property (p_len) else $error("length upper byte");
    property p_irq;
        frame_irq_out |-> $past(frame_done_in) && $past(irq_source_sel_out);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    property p_acc; frame_accept_out |-> $past(frame_done_in); endproperty
    a_acc: assert property (p_acc) else $error("accept without frame");
    property p_trunc;
        detect_buffer_size_out != 4'h0 |-> !truncate_frame_out;
    endproperty
    a_trunc: assert property (p_trunc) else $error("truncate with buffer");
    property p_wen;
        !$past(rst_in, 2) && $changed(frame_write_en_out)
        |-> $past(reg_wr_in) && $past(reg_addr_in) == 5'h1f;
    endproperty
    a_wen: assert property (p_wen) else $error("enable changed alone");
endmodule

bind pcfr_regs pcfr_regs_assertions #(.SLOW_CYC(SLOW_CYC)) chk_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .page_select_in(page_select_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .frame_done_in(frame_done_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .frame_accept_out(frame_accept_out),
    .frame_write_en_out(frame_write_en_out),
    .detect_buffer_size_out(detect_buffer_size_out),
    .truncate_frame_out(truncate_frame_out),
    .frame_irq_out(frame_irq_out), .irq_source_sel_out(irq_source_sel_out)
);

// file: tb/pcfr_mac_model.sv
// Purpose: MAC side source of ended control frames
// Assumes: Driven off the falling edge of the system clock
// Notes:   Frame fields only hold while the end pulse is high
`timescale 1ns/1ps
module pcfr_mac_model (
    input  wire logic   clk_sys_in, // System clock
    output logic        done_out,   // Frame ended pulse
    output logic        fault_out,  // Frame faulty
    output logic [47:0] da_out,     // Destination address
    output logic [4:0]  phy_out     // PHY address field
);
    // Idle outputs before the first frame
    initial begin
        done_out = 1'b0;
        fault_out = 1'b0;
        da_out = '1;
        phy_out = '1;
    end

    // One ended frame for one cycle; fields scrambled afterwards
    task automatic send(input logic f, input logic [47:0] d,
                        input logic [4:0] p);
        @(negedge clk_sys_in);
        done_out = 1'b1;
        fault_out = f;
        da_out = d;
        phy_out = p;
        @(negedge clk_sys_in);
        done_out = 1'b0;
        fault_out = ~f;
        da_out = ~d;
        phy_out = ~p;
    endtask
endmodule

// file: tb/pcfr_regs_tb.sv
// Purpose: Self-checking bench for the control-frame register bank
// Assumes: Slow loss limit shortened to 50 cycles
// Notes:   Random values come from a fixed-seed shift register
`timescale 1ns/1ps
module pcfr_regs_tb;
    localparam logic [47:0] DA_A = 48'h0a_00_00_00_00_01; // Arbitrary
    localparam logic [47:0] DA_B = 48'h0a_00_00_00_00_00; // Arbitrary
    localparam logic [47:0] MC   = 48'h01_00_00_00_00_00;
    logic clk_sys_in = 0, rst_in = 1, rd = 0, wr = 0, sig = 1, lval = 0;
    logic strap = 1;
    logic [2:0]  page = 0;
    logic [4:0]  addr = 0, phy;
    logic [15:0] wdata = 0, rdata;
    logic [7:0]  len = 0;
    logic [47:0] da;
    logic [3:0]  bsz;
    logic [31:0] lfsr = 32'hf052;
    logic done, fault, hit, acc, wen, trunc, irq, isel, lok;
    int miscompares = 0, samples_checked = 0;

    always #2 clk_sys_in = ~clk_sys_in;

    pcfr_mac_model mac_u (.clk_sys_in(clk_sys_in), .done_out(done),
        .fault_out(fault), .da_out(da), .phy_out(phy));
    pcfr_regs #(.DEST_ADDR_A(DA_A), .DEST_ADDR_B(DA_B), .SLOW_CYC(50)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .strap_frame_en_in(strap),
        .page_select_in(page), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .frame_done_in(done),
        .frame_fault_in(fault), .frame_da_in(da), .frame_phy_addr_in(phy),
        .own_phy_addr_in(5'h05), .link_100_in(1'b1),
        .length_meters_in(len), .length_valid_in(lval),
        .sig_detect_in(sig), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .frame_accept_out(acc), .frame_write_en_out(wen),
        .detect_buffer_size_out(bsz), .truncate_frame_out(trunc),
        .frame_irq_out(irq), .irq_source_sel_out(isel), .link_ok_out(lok));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic exp_acc(input logic [47:0] d,
                                     input logic [4:0] p, input logic [15:0] c);
        logic [47:0] s;
        s = c[8] ? DA_B : DA_A;
        return (d == s || d == (s | MC)) && (p == 5'h05 || (!c[5] && p == 5'h1f));
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One strobe cycle; read answer is settled on return
    task automatic acc_reg(input logic w, input logic [2:0] p,
                           input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        page = p;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk_sys_in);
        wr = 0;
        rd = 0;
    endtask
    task automatic results;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Times the loss of link after the detect signal drops
    task automatic loss(input logic [15:0] sd, input int lo, input int hi);
        int n;
        acc_reg(1, 1, 5'h1e, sd);
        chk({15'h0, lok}, 16'h1);
        sig = 0;
        n = 0;
        while (lok === 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk({15'h0, n >= lo && n <= hi}, 16'h1);
        if (n >= 400) results();
        sig = 1;
        repeat (8) @(negedge clk_sys_in);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [15:0] c;
        logic [47:0] d;
        logic [4:0]  p;
        logic        f;
        logic [4:0]  ad [3] = '{5'h1f, 5'h1e, 5'h14};
        repeat (10) @(negedge clk_sys_in);
        rst_in = 0;
        repeat (2) @(negedge clk_sys_in);
        acc_reg(0, 0, 5'h1f, 0);
        chk(rdata, 16'h0001);
        acc_reg(0, 2, 5'h14, 0);
        chk(rdata, 16'h00ff);
        acc_reg(0, 1, 5'h1e, 0);
        chk(rdata, 16'h8000);
        acc_reg(0, 0, 5'h03, 0);
        chk({hit, rdata[14:0]}, 16'h0);
        foreach (ad[j]) for (int k = 0; k < 8; k++) begin
            acc_reg(0, k[2:0], ad[j], 0);
            chk({15'h0, hit}, {15'h0, k == j});
        end
        for (int i = 0; i < 8; i++) begin
            repeat (32) lfsr = nx(lfsr);
            acc_reg(1, 0, 5'h1f, lfsr[15:0]);
            acc_reg(1, 1, 5'h1f, ~lfsr[15:0]);
            acc_reg(0, 0, 5'h1f, 0);
            chk(rdata, lfsr[15:0] & 16'h01ff);
            chk({9'h0, isel, trunc, wen, bsz}, {9'h0, |lfsr[7:6],
                lfsr[4:1] == 4'h0, lfsr[0], lfsr[4:1]});
        end
        acc_reg(1, 1, 5'h1e, 16'h8100);
        acc_reg(0, 1, 5'h1e, 0);
        chk(rdata, 16'h8100);
        loss(16'h8000, 45, 60);
        loss(16'h8100, 245, 262);
        for (int i = 0; i < 40; i++) begin
            repeat (32) lfsr = nx(lfsr);
            c = (lfsr[15:0] & 16'h01ff) | 16'h0001;
            d = (lfsr[17] ? DA_B : DA_A) | (lfsr[18] ? MC : 48'h0);
            if (lfsr[19] & lfsr[20]) d = d ^ 48'h10;
            p = lfsr[21] ? 5'h1f : (lfsr[22] ? 5'h05 : lfsr[27:23]);
            f = lfsr[28];
            acc_reg(1, 0, 5'h1f, c);
            mac_u.send(f, d, p);
            chk({15'h0, acc}, {15'h0, exp_acc(d, p, c)});
            if (exp_acc(d, p, c)) begin
                chk({15'h0, irq}, {15'h0, c[6] & !f | c[7] & f});
                acc_reg(0, 0, 5'h1f, 0);
                chk(rdata, {f, !f, c[13:0]});
            end
            acc_reg(0, 0, 5'h1f, 0);
            chk(rdata, c);
        end
        acc_reg(1, 0, 5'h1f, 16'h0041);
        fork
            mac_u.send(0, DA_A, 5'h1f);
            acc_reg(0, 0, 5'h1f, 0);
        join
        chk(rdata, 16'h0041);
        acc_reg(0, 0, 5'h1f, 0);
        chk(rdata, 16'h4041);
        len = lfsr[7:0];
        lval = 1;
        acc_reg(0, 2, 5'h14, 0);
        chk(rdata, {8'h0, len});
        // Mid-run reset with the strap low: enable must come up clear
        strap = 0;
        rst_in = 1;
        repeat (3) @(negedge clk_sys_in);
        rst_in = 0;
        repeat (2) @(negedge clk_sys_in);
        chk({14'h0, wen, trunc}, 16'h0001);
        acc_reg(0, 0, 5'h1f, 0);
        chk(rdata, 16'h0000);
        results();
    end
endmodule
